/* File: hw/sfd_defs.vh */
// Constants for the supply fault detector block.
// Functional notes
// - There are eight channels: four dedicated detectors and four dual-function channels that are either analog detectors or logic inputs.
// - Each detector flags undervoltage, overvoltage or out-of-window faults as selected.
// - Thresholds are 8-bit codes scaled over the range span divided by 255.
// - Four input ranges exist, from the 0.573 V range up to the 6.0 V bottom, 8.4 V span range.
// - The high-voltage channel takes the two upper ranges, positive channels the three lower, dual-function channels only the lowest.
// - Hysteresis applies only once a fault is raised, raising the clear level for undervoltage and lowering it for overvoltage.
// - Hysteresis is a 5-bit code in the same code units as the thresholds.
// - Each channel's detector or logic input passes through a glitch filter programmable from zero to 100 us; warning detectors are not filtered.
// - The filter drops pulses shorter than the timeout and passes longer ones.
// - The filter output follows an accepted transition after a delay of the timeout plus one clock.
// - A dual-function channel in logic use is a digital input, not compared against thresholds.
// - In logic use its detector becomes a warning detector on a dedicated channel, the first three on the positive channels in order and the fourth on the high-voltage channel.
`ifndef SFD_DEFS_VH
`define SFD_DEFS_VH
`define SFD_NUM_CH 8
`define SFD_CODE_W 8
`define SFD_HYST_W 5
`define SFD_CLK_MHZ 20
`define SFD_FILT_MAX_US 100
`define SFD_FILT_MAX_TICKS 11'h7d0
`define SFD_FILT_W 11
`define SFD_MODE_UV 2'h0
`define SFD_MODE_OV 2'h1
`define SFD_MODE_WIN 2'h2
`define SFD_MODE_OFF 2'h3
`define SFD_RANGE_LOW 2'h0
`define SFD_RANGE_MID 2'h1
`define SFD_RANGE_HIGH 2'h2
`define SFD_RANGE_TOP 2'h3
`endif

/* File: hw/sfd_glitch_filter.v */
// Glitch filter: a level must stand for the timeout before the output follows it.
`timescale 1ns/1ns
`default_nettype none
`include "sfd_defs.vh"
module sfd_glitch_filter
(
   // Clock and reset.
   input wire sys_clk_in,
   input wire reset_in,
   // Filter setting and data.
   input wire [`SFD_FILT_W-1:0] timeout_in,
   input wire raw_in,
   output reg filt_out
);
   reg [`SFD_FILT_W-1:0] cnt_ff;
   reg [`SFD_FILT_W-1:0] lim;

   always @*
   begin
      lim = timeout_in;
      if (timeout_in > `SFD_FILT_MAX_TICKS)
      begin
         lim = `SFD_FILT_MAX_TICKS;
      end
   end

   // A differing input counts up; any return to the output level restarts it.
   always @(posedge sys_clk_in)
   begin
      if (reset_in)
      begin
         cnt_ff <= {`SFD_FILT_W{1'b0}};
         filt_out <= 1'b0;
      end
      else if (raw_in == filt_out)
      begin
         cnt_ff <= {`SFD_FILT_W{1'b0}};
      end
      else if (cnt_ff >= lim)
      begin
         filt_out <= raw_in;
         cnt_ff <= {`SFD_FILT_W{1'b0}};
      end
      else
      begin
         cnt_ff <= cnt_ff + 1'b1;
      end
   end
endmodule
`default_nettype wire

/* File: hw/sfd_top.v */
// Eight-channel supply fault detector with hysteresis and glitch filters.
`timescale 1ns/1ns
`default_nettype none
`include "sfd_defs.vh"
module sfd_top
(
   // Clock and reset.
   input wire sys_clk_in,
   input wire reset_in,
   // Digitised channel codes, channel 0 high voltage, 1-3 positive, 4-7 dual function.
   input wire [8*`SFD_CODE_W-1:0] chan_code_in,
   // Dual-function logic levels, one per channel 4-7.
   input wire [3:0] dual_function_input_in,
   // Dual-function use: 1 selects logic input.
   input wire [3:0] dual_logic_sel_in,
   // Per-channel configuration.
   input wire [8*2-1:0] chan_mode_in,
   input wire [8*2-1:0] chan_range_in,
   input wire [8*`SFD_CODE_W-1:0] channel_undervoltage_threshold_in,
   input wire [8*`SFD_CODE_W-1:0] channel_overvoltage_threshold_in,
   input wire [8*`SFD_HYST_W-1:0] hysteresis_code_in,
   input wire [8*`SFD_FILT_W-1:0] filt_ticks_in,
   // Results: faults and logic levels filtered, warnings and range errors unfiltered.
   output reg [7:0] fault_out,
   output reg [3:0] warning_out,
   output reg [3:0] logic_level_out,
   output reg [7:0] range_error_out
);
   wire [7:0] filt;
   reg [7:0] undervoltage_fault_ff;
   reg [7:0] overvoltage_fault_ff;
   reg [7:0] nxt_uv;
   reg [7:0] nxt_ov;
   reg [7:0] raw;
   reg [7:0] rng_bad;
   reg [8:0] code;
   reg [8:0] uvt;
   reg [8:0] ovt;
   reg [8:0] hys;
   reg [1:0] mode;
   reg [1:0] rng;
   integer i;

   // Comparators with hysteresis, evaluated on every channel every cycle.
   always @*
   begin
      nxt_uv = 8'h00;
      nxt_ov = 8'h00;
      raw = 8'h00;
      rng_bad = 8'h00;
      code = 9'h000;
      uvt = 9'h000;
      ovt = 9'h000;
      hys = 9'h000;
      mode = 2'h0;
      rng = 2'h0;
      for (i = 0; i < 8; i = i + 1)
      begin
         code = {1'b0, chan_code_in[i*8 +: 8]};
         uvt = {1'b0, channel_undervoltage_threshold_in[i*8 +: 8]};
         ovt = {1'b0, channel_overvoltage_threshold_in[i*8 +: 8]};
         hys = {4'h0, hysteresis_code_in[i*5 +: 5]};
         mode = chan_mode_in[i*2 +: 2];
         rng = chan_range_in[i*2 +: 2];
         // Undervoltage clears only above threshold plus hysteresis.
         if (undervoltage_fault_ff[i])
         begin
            nxt_uv[i] = (code <= uvt + hys);
         end
         else
         begin
            nxt_uv[i] = (code < uvt);
         end
         // Overvoltage clears only below threshold minus hysteresis.
         if (overvoltage_fault_ff[i])
         begin
            nxt_ov[i] = (code + hys >= ovt);
         end
         else
         begin
            nxt_ov[i] = (code > ovt);
         end
         case (mode)
            `SFD_MODE_UV: raw[i] = undervoltage_fault_ff[i];
            `SFD_MODE_OV: raw[i] = overvoltage_fault_ff[i];
            `SFD_MODE_WIN: raw[i] = undervoltage_fault_ff[i] | overvoltage_fault_ff[i];
            default: raw[i] = 1'b0;
         endcase
         // Ranges allowed per channel type.
         if (i == 0)
         begin
            rng_bad[i] = (rng != `SFD_RANGE_HIGH) && (rng != `SFD_RANGE_TOP);
         end
         else if (i < 4)
         begin
            rng_bad[i] = (rng == `SFD_RANGE_TOP);
         end
         else
         begin
            rng_bad[i] = (rng != `SFD_RANGE_LOW);
         end
      end
      // Logic-use channels feed their pin level to the filter instead.
      for (i = 0; i < 4; i = i + 1)
      begin
         if (dual_logic_sel_in[i])
         begin
            raw[4+i] = dual_function_input_in[i];
         end
      end
   end

   always @(posedge sys_clk_in)
   begin
      if (reset_in)
      begin
         undervoltage_fault_ff <= 8'h00;
         overvoltage_fault_ff <= 8'h00;
      end
      else
      begin
         undervoltage_fault_ff <= nxt_uv;
         overvoltage_fault_ff <= nxt_ov;
      end
   end

   genvar g;
   generate
      for (g = 0; g < 8; g = g + 1)
      begin : gen_filt
         sfd_glitch_filter u_filt
         (
            .sys_clk_in(sys_clk_in),
            .reset_in(reset_in),
            .timeout_in(filt_ticks_in[g*`SFD_FILT_W +: `SFD_FILT_W]),
            .raw_in(raw[g]),
            .filt_out(filt[g])
         );
      end
   endgenerate

   // Detector of a logic-use dual channel supervises a dedicated channel as a warning.
   // The warning compares the dedicated channel code against the dual channel settings.
   reg [3:0] warn_uv_ff;
   reg [3:0] warn_ov_ff;
   reg [3:0] nxt_wuv;
   reg [3:0] nxt_wov;
   reg [3:0] warn_raw;
   reg [8:0] wcode;
   reg [8:0] wuvt;
   reg [8:0] wovt;
   reg [8:0] whys;
   reg [1:0] wmode;
   integer j;

   always @*
   begin
      nxt_wuv = 4'h0;
      nxt_wov = 4'h0;
      warn_raw = 4'h0;
      wcode = 9'h000;
      wuvt = 9'h000;
      wovt = 9'h000;
      whys = 9'h000;
      wmode = 2'h0;
      for (j = 0; j < 4; j = j + 1)
      begin
         // Dual 0-2 map to positive 1-3, dual 3 maps to the high-voltage channel.
         wcode = {1'b0, chan_code_in[((j == 3) ? 0 : j + 1)*8 +: 8]};
         wuvt = {1'b0, channel_undervoltage_threshold_in[(4+j)*8 +: 8]};
         wovt = {1'b0, channel_overvoltage_threshold_in[(4+j)*8 +: 8]};
         whys = {4'h0, hysteresis_code_in[(4+j)*5 +: 5]};
         wmode = chan_mode_in[(4+j)*2 +: 2];
         if (warn_uv_ff[j])
         begin
            nxt_wuv[j] = (wcode <= wuvt + whys);
         end
         else
         begin
            nxt_wuv[j] = (wcode < wuvt);
         end
         if (warn_ov_ff[j])
         begin
            nxt_wov[j] = (wcode + whys >= wovt);
         end
         else
         begin
            nxt_wov[j] = (wcode > wovt);
         end
         case (wmode)
            `SFD_MODE_UV: warn_raw[j] = warn_uv_ff[j];
            `SFD_MODE_OV: warn_raw[j] = warn_ov_ff[j];
            `SFD_MODE_WIN: warn_raw[j] = warn_uv_ff[j] | warn_ov_ff[j];
            default: warn_raw[j] = 1'b0;
         endcase
      end
   end

   always @(posedge sys_clk_in)
   begin
      if (reset_in)
      begin
         warn_uv_ff <= 4'h0;
         warn_ov_ff <= 4'h0;
         fault_out <= 8'h00;
         warning_out <= 4'h0;
         logic_level_out <= 4'h0;
         range_error_out <= 8'h00;
      end
      else
      begin
         warn_uv_ff <= nxt_wuv;
         warn_ov_ff <= nxt_wov;
         // A channel is either a detector or a logic input, never both.
         fault_out <= filt & {~dual_logic_sel_in, 4'hf};
         logic_level_out <= filt[7:4] & dual_logic_sel_in;
         warning_out <= warn_raw & dual_logic_sel_in;
         range_error_out <= rng_bad & {~dual_logic_sel_in, 4'hf};
      end
   end
endmodule
`default_nettype wire

/* File: verification/sfd_properties.sv */
// Port assertions for the supply fault detector.
`timescale 1ns/1ns
`default_nettype none
module sfd_properties
(
   // Clock and reset.
   input wire logic sys_clk_in,
   input wire logic reset_in,
   // Watched inputs.
   input wire logic [63:0] chan_code_in,
   input wire logic [3:0] dual_logic_sel_in,
   input wire logic [15:0] chan_mode_in,
   input wire logic [15:0] chan_range_in,
   input wire logic [63:0] channel_undervoltage_threshold_in,
   // Watched outputs.
   input wire logic [7:0] fault_out,
   input wire logic [3:0] warning_out,
   input wire logic [3:0] logic_level_out,
   input wire logic [7:0] range_error_out
);
   // ==========
   // Checks
   default clocking @(posedge sys_clk_in); endclocking
   default disable iff (reset_in);
   a_reset_clears_all: assert property ($fell(reset_in) |-> {fault_out, warning_out,
      logic_level_out, range_error_out} == 24'h0) else $error("outputs not clear");
   a_range_hv_only: assert property (!$past(reset_in) |->
      range_error_out[0] == !$past(chan_range_in[1])) else $error("range ch0");
   a_range_pos_set: assert property (!$past(reset_in) |->
      range_error_out[1] == ($past(chan_range_in[3:2]) == 2'h3)) else $error("range ch1");
   a_range_dual_low: assert property (!$past(reset_in) |->
      range_error_out[4] == ($past(chan_range_in[9:8]) != 2'h0 && !$past(dual_logic_sel_in[0])))
      else $error("range ch4");
   a_logic_no_fault: assert property ((fault_out[7:4] & $past(dual_logic_sel_in) &
      $past(dual_logic_sel_in, 2)) == 4'h0) else $error("fault on logic channel");
   a_off_no_rise: assert property ($rose(fault_out[0]) |->
      $past(chan_mode_in[1:0], 2) != 2'h3) else $error("fault while off");
   a_warn_needs_logic: assert property ($rose(warning_out[0]) |->
      $past(dual_logic_sel_in[0])) else $error("warning without logic use");
   a_warn_uv_cause: assert property ($rose(warning_out[0]) && $past(chan_mode_in[9:8], 2) ==
      2'h0 && $past(chan_mode_in[9:8]) == 2'h0 && $past(dual_logic_sel_in[0], 2) |->
      $past(chan_code_in[15:8], 2) < $past(channel_undervoltage_threshold_in[39:32], 2))
      else $error("warning without cause");
endmodule
bind sfd_top sfd_properties u_props (.sys_clk_in(sys_clk_in), .reset_in(reset_in),
   .chan_code_in(chan_code_in), .dual_logic_sel_in(dual_logic_sel_in),
   .chan_mode_in(chan_mode_in), .chan_range_in(chan_range_in),
   .channel_undervoltage_threshold_in(channel_undervoltage_threshold_in),
   .fault_out(fault_out), .warning_out(warning_out), .logic_level_out(logic_level_out),
   .range_error_out(range_error_out));
`default_nettype wire

/* File: verification/sfd_top_tb.sv */
// Self-checking bench for the supply fault detector.
`timescale 1ns/1ns
`default_nettype none
module sfd_top_tb;
   logic sys_clk_in, reset_in;
   logic [63:0] code, uvth, ovth;
   logic [3:0] din, sel, warn, lvl;
   logic [15:0] mode, rng;
   logic [39:0] hys;
   logic [87:0] ft;
   logic [7:0] fault, rerr;
   int failures, samples_checked;
   sfd_top uut (.sys_clk_in(sys_clk_in), .reset_in(reset_in), .chan_code_in(code),
      .dual_function_input_in(din), .dual_logic_sel_in(sel), .chan_mode_in(mode),
      .chan_range_in(rng), .channel_undervoltage_threshold_in(uvth),
      .channel_overvoltage_threshold_in(ovth), .hysteresis_code_in(hys),
      .filt_ticks_in(ft), .fault_out(fault), .warning_out(warn),
      .logic_level_out(lvl), .range_error_out(rerr));
   // ==========
   // Helpers
   task automatic wt(input int n);
      repeat (n) @(negedge sys_clk_in);
   endtask
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      samples_checked++;
      if (g !== e)
      begin
         failures++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic do_reset;
      reset_in = 1'b1;
      wt(4);
      reset_in = 1'b0;
   endtask
   task automatic finish_test;
      $display("failures %0d samples_checked %0d", failures, samples_checked);
      if (failures == 0 && samples_checked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   function automatic logic exp_rng(input int c, input logic [1:0] r);
      if (c == 0)
         return r < 2'h2;
      if (c < 4)
         return r == 2'h3;
      return r != 2'h0;
   endfunction
   function automatic logic exp_flt(input logic [1:0] m, input logic [7:0] v, u, o);
      return (m[0] == 1'b0 && v < u) || (m != 2'h0 && m != 2'h3 && v > o);
   endfunction
   // ==========
   // Stimulus
   initial
   begin
      sys_clk_in = 1'b0;
      forever #25 sys_clk_in = ~sys_clk_in;
   end
   initial
   begin
      failures = 0;
      samples_checked = 0;
      void'($urandom(32'hf4b40538));
      code = {8{8'hf0}};
      uvth = {8{8'h80}};
      ovth = {8{8'hfe}};
      din = 4'h5;
      sel = 4'h0;
      mode = 16'h0000;
      rng = 16'h0002;
      hys = 40'h0;
      ft = 88'h0;
      ft[21:11] = 11'h004;
      hys[9:5] = 5'h05;
      do_reset;
      wt(2);
      code[15:8] = 8'h7f;
      wt(4);
      code[15:8] = 8'hf0;
      wt(8);
      chk("glitch", 8'h00, fault);
      code[15:8] = 8'h7f;
      wt(6);
      chk("early", 8'h00, fault);
      wt(1);
      chk("delay", 8'h02, fault);
      code[15:8] = 8'h85;
      wt(12);
      chk("hyst_hold", 8'h02, fault);
      code[15:8] = 8'h86;
      wt(12);
      chk("hyst_clear", 8'h00, fault);
      for (int i = 0; i < 12; i++)
      begin
         mode[5:4] = i[1:0];
         uvth[23:16] = 8'($urandom);
         ovth[23:16] = 8'($urandom);
         code[23:16] = 8'($urandom);
         do_reset;
         wt(4);
         chk("mode", {5'h0, exp_flt(mode[5:4], code[23:16], uvth[23:16], ovth[23:16]), 2'h0},
            fault);
      end
      for (int i = 0; i < 16; i++)
      begin
         rng = 16'($urandom);
         wt(3);
         for (int c = 0; c < 8; c++)
            chk("range", {7'h0, exp_rng(c, rng[2*c +: 2])}, {7'h0, rerr[c]});
      end
      rng = 16'hff02;
      mode = 16'h0000;
      uvth = {8{8'h80}};
      ovth = {8{8'hfe}};
      sel = 4'hf;
      for (int j = 0; j < 4; j++)
      begin
         int m;
         m = (j == 3) ? 0 : j + 1;
         code = {8{8'hf0}};
         code[8*m +: 8] = 8'h10;
         din = ~din;
         wt(8);
         chk("warn", 8'h01 << j, {4'h0, warn});
         chk("logic", {4'h0, din}, {4'h0, lvl});
         chk("fault", 8'h01 << m, fault);
         chk("range_logic", 8'h00, rerr);
      end
      finish_test;
   end
endmodule
`default_nettype wire
